// >>> design/amt_pkg.sv
// How it works
// [RULE1] Alarm 0 date: bits 7-6 read zero, tens 5-4, units 3-0.
// [RULE2] Alarm 0 month at 0x11: bits 7-5 zero, tens bit 4, units 3-0.
// [RULE3] Month comparison exists for alarm 0 only.
// [RULE4] Alarm 1 sub-second at 0x12: tenths 7-4, hundredths 3-0, all writable.
// [RULE5] Sub-second comparison exists for alarm 1 only.
// [RULE6] Alarm 1 seconds at 0x13: bit 7 zero, tens 6-4, units 3-0.
// [RULE7] Alarm 1 minutes at 0x14: bit 7 zero, tens 6-4, units 3-0.
// [RULE8] Alarm 1 hours at 0x15: bit 7 zero, 12/24 bit 6, bit 5 dual.
// [RULE9] Unimplemented bits ignore writes; fields compare digitwise in BCD.
`default_nettype none
package amt_pkg;
    localparam logic [7:0] ADDR_DATE0   = 8'h10;
    localparam logic [7:0] ADDR_MONTH0  = 8'h11;
    localparam logic [7:0] ADDR_SUBSEC1 = 8'h12;
    localparam logic [7:0] ADDR_SEC1    = 8'h13;
    localparam logic [7:0] ADDR_MIN1    = 8'h14;
    localparam logic [7:0] ADDR_HOUR1   = 8'h15;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h30;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h31;
    localparam logic [7:0] ADDR_MATCH_EN = 8'h32;

    localparam logic [7:0] MASK_DATE   = 8'h3f;
    localparam logic [7:0] MASK_MONTH  = 8'h1f;
    localparam logic [7:0] MASK_SUBSEC = 8'hff;
    localparam logic [7:0] MASK_SEC    = 8'h7f;
    localparam logic [7:0] MASK_MIN    = 8'h7f;
    localparam logic [7:0] MASK_HOUR   = 8'h7f;
    localparam logic [7:0] MASK_IRQ    = 8'h03;
    localparam logic [7:0] MASK_EN     = 8'h3f;
    localparam logic [7:0] RESET_ZERO  = 8'h00;

    localparam int BIT_HOUR_12 = 6;
    localparam int BIT_MERIDIEM = 5;
    localparam int IRQ_ALM0 = 0;
    localparam int IRQ_ALM1 = 1;
    localparam int NUM_FIELDS = 6;

    // Enable bits in match_enable: 0 date0, 1 month0, 2 subsec1,
    // 3 sec1, 4 min1, 5 hour1
    localparam int EN_DATE0 = 0;
    localparam int EN_MONTH0 = 1;
    localparam int EN_SUBSEC1 = 2;
    localparam int EN_SEC1 = 3;
    localparam int EN_MIN1 = 4;
    localparam int EN_HOUR1 = 5;

    typedef struct packed {
        logic [7:0] subsec;
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
    } amt_time_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } amt_bus_req_t;
endpackage
`default_nettype wire

// >>> design/amt_digit_cmp.sv
`timescale 1ns/1ns
`default_nettype none
module amt_digit_cmp (
    input  wire logic [7:0] cmp_val,  // Stored compare value
    input  wire logic [7:0] cur_val,  // Running counter value
    input  wire logic [7:0] mask,     // Implemented bits
    output logic            hit       // All digits equal
);
    // Digitwise BCD compare over implemented bits only
    assign hit = ((cmp_val ^ cur_val) & mask) == 8'h00; // [RULE9]
endmodule
`default_nettype wire

// >>> design/amt_alarm_regs.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module amt_alarm_regs (
    input  wire logic                clk_sys,   // 10 MHz clock
    input  wire logic                rst,       // Sync reset, high
    input  wire amt_pkg::amt_bus_req_t bus_req, // Register request
    output logic [7:0]               rdata,     // Read data, next cycle
    input  wire amt_pkg::amt_time_t  now,       // Running BCD counters
    output logic                     alm0_hit,  // Alarm 0 match level
    output logic                     alm1_hit,  // Alarm 1 match level
    output logic                     irq        // Level interrupt
);

    ////////////////////////////////////////////////////////////////////
    // Compare registers
    logic [7:0] date0;
    logic [7:0] month0;
    logic [7:0] subsec1;
    logic [7:0] sec1;
    logic [7:0] min1;
    logic [7:0] hour1;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [7:0] match_en;

    logic wr_hit;
    assign wr_hit = bus_req.wr;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            date0 <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_DATE0) begin
            date0 <= bus_req.wdata & amt_pkg::MASK_DATE; // [RULE1] [RULE9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            month0 <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_MONTH0) begin
            month0 <= bus_req.wdata & amt_pkg::MASK_MONTH; // [RULE2] [RULE9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            subsec1 <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_SUBSEC1) begin
            subsec1 <= bus_req.wdata & amt_pkg::MASK_SUBSEC; // [RULE4]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sec1 <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_SEC1) begin
            sec1 <= bus_req.wdata & amt_pkg::MASK_SEC; // [RULE6] [RULE9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            min1 <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_MIN1) begin
            min1 <= bus_req.wdata & amt_pkg::MASK_MIN; // [RULE7] [RULE9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hour1 <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_HOUR1) begin
            hour1 <= bus_req.wdata & amt_pkg::MASK_HOUR; // [RULE8] [RULE9]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            match_en <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_MATCH_EN) begin
            match_en <= bus_req.wdata & amt_pkg::MASK_EN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_mask <= amt_pkg::RESET_ZERO;
        end else if (wr_hit && bus_req.addr == amt_pkg::ADDR_IRQ_MSK) begin
            irq_mask <= bus_req.wdata & amt_pkg::MASK_IRQ;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Field compare, one comparator per field
    logic [7:0] cmp_vals [amt_pkg::NUM_FIELDS];
    logic [7:0] cur_vals [amt_pkg::NUM_FIELDS];
    logic [7:0] masks    [amt_pkg::NUM_FIELDS];
    logic [amt_pkg::NUM_FIELDS-1:0] field_hit;

    assign cmp_vals[amt_pkg::EN_DATE0]   = date0;
    assign cmp_vals[amt_pkg::EN_MONTH0]  = month0;
    assign cmp_vals[amt_pkg::EN_SUBSEC1] = subsec1;
    assign cmp_vals[amt_pkg::EN_SEC1]    = sec1;
    assign cmp_vals[amt_pkg::EN_MIN1]    = min1;
    assign cmp_vals[amt_pkg::EN_HOUR1]   = hour1;
    assign cur_vals[amt_pkg::EN_DATE0]   = now.date;
    assign cur_vals[amt_pkg::EN_MONTH0]  = now.month;
    assign cur_vals[amt_pkg::EN_SUBSEC1] = now.subsec;
    assign cur_vals[amt_pkg::EN_SEC1]    = now.sec;
    assign cur_vals[amt_pkg::EN_MIN1]    = now.min;
    assign cur_vals[amt_pkg::EN_HOUR1]   = now.hour;
    assign masks[amt_pkg::EN_DATE0]      = amt_pkg::MASK_DATE;
    assign masks[amt_pkg::EN_MONTH0]     = amt_pkg::MASK_MONTH;
    assign masks[amt_pkg::EN_SUBSEC1]    = amt_pkg::MASK_SUBSEC;
    assign masks[amt_pkg::EN_SEC1]       = amt_pkg::MASK_SEC;
    assign masks[amt_pkg::EN_MIN1]       = amt_pkg::MASK_MIN;
    assign masks[amt_pkg::EN_HOUR1]      = amt_pkg::MASK_HOUR;

    genvar gi;
    generate
        for (gi = 0; gi < amt_pkg::NUM_FIELDS; gi++) begin : g_cmp
            amt_digit_cmp u_cmp (
                .cmp_val (cmp_vals[gi]),
                .cur_val (cur_vals[gi]),
                .mask    (masks[gi]),
                .hit     (field_hit[gi])
            );
        end
    endgenerate

    // Disabled fields count as matching; an alarm with no field
    // enabled never fires, so reset leaves both alarms quiet
    logic [amt_pkg::NUM_FIELDS-1:0] ok;
    assign ok = field_hit | ~match_en[amt_pkg::NUM_FIELDS-1:0];

    logic next_alm0;
    logic next_alm1;
    // Month only on alarm 0, sub-second only on alarm 1
    assign next_alm0 = ok[amt_pkg::EN_DATE0] && ok[amt_pkg::EN_MONTH0]
        && (match_en[amt_pkg::EN_DATE0] || match_en[amt_pkg::EN_MONTH0]);
        // [RULE3]
    assign next_alm1 = ok[amt_pkg::EN_SUBSEC1] && ok[amt_pkg::EN_SEC1]
        && ok[amt_pkg::EN_MIN1] && ok[amt_pkg::EN_HOUR1]
        && (match_en[amt_pkg::EN_SUBSEC1] || match_en[amt_pkg::EN_SEC1]
        || match_en[amt_pkg::EN_MIN1] || match_en[amt_pkg::EN_HOUR1]);
        // [RULE5]

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            alm0_hit <= 1'b0;
            alm1_hit <= 1'b0;
        end else begin
            alm0_hit <= next_alm0;
            alm1_hit <= next_alm1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky status on rising match; set wins over write-one clear
    logic rise0;
    logic rise1;
    assign rise0 = next_alm0 && !alm0_hit;
    assign rise1 = next_alm1 && !alm1_hit;

    logic [7:0] clr_bits;
    assign clr_bits = (wr_hit && bus_req.addr == amt_pkg::ADDR_IRQ_ST)
        ? (bus_req.wdata & amt_pkg::MASK_IRQ) : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq_status <= amt_pkg::RESET_ZERO;
        end else begin
            irq_status <= (irq_status & ~clr_bits)
                | {6'h00, rise1, rise0};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask & ~clr_bits)
                || (irq_mask[amt_pkg::IRQ_ALM0] && rise0)
                || (irq_mask[amt_pkg::IRQ_ALM1] && rise1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read port; unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                amt_pkg::ADDR_DATE0:    rdata <= date0;   // [RULE1]
                amt_pkg::ADDR_MONTH0:   rdata <= month0;  // [RULE2]
                amt_pkg::ADDR_SUBSEC1:  rdata <= subsec1; // [RULE4]
                amt_pkg::ADDR_SEC1:     rdata <= sec1;    // [RULE6]
                amt_pkg::ADDR_MIN1:     rdata <= min1;    // [RULE7]
                amt_pkg::ADDR_HOUR1:    rdata <= hour1;   // [RULE8]
                amt_pkg::ADDR_IRQ_ST:   rdata <= irq_status;
                amt_pkg::ADDR_IRQ_MSK:  rdata <= irq_mask;
                amt_pkg::ADDR_MATCH_EN: rdata <= match_en;
                default:                rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_wr(logic [7:0] a);
        bus_req.wr && bus_req.addr == a;
    endsequence

    sequence s_rd(logic [7:0] a);
        bus_req.rd && bus_req.addr == a;
    endsequence

    property p_date_zero;
        @(posedge clk_sys) disable iff (rst)
        s_rd(amt_pkg::ADDR_DATE0) |=> rdata[7:6] == 2'b00;
    endproperty
    a_date_zero: assert property (p_date_zero) // [RULE1]
        else $error("date top bits not zero");

    property p_month_rt;
        @(posedge clk_sys) disable iff (rst)
        s_wr(amt_pkg::ADDR_MONTH0) ##1 s_rd(amt_pkg::ADDR_MONTH0)
        |=> rdata == ($past(bus_req.wdata, 2) & amt_pkg::MASK_MONTH);
    endproperty
    a_month_rt: assert property (p_month_rt) // [RULE2]
        else $error("month readback wrong");

    property p_month_only0;
        @(posedge clk_sys) disable iff (rst)
        (match_en[amt_pkg::EN_MONTH0] && !field_hit[amt_pkg::EN_MONTH0])
        |=> !alm0_hit;
    endproperty
    a_month_only0: assert property (p_month_only0) // [RULE3]
        else $error("alarm 0 hit despite month mismatch");

    property p_subsec_rt;
        @(posedge clk_sys) disable iff (rst)
        s_wr(amt_pkg::ADDR_SUBSEC1) ##1 s_rd(amt_pkg::ADDR_SUBSEC1)
        |=> rdata == $past(bus_req.wdata, 2);
    endproperty
    a_subsec_rt: assert property (p_subsec_rt) // [RULE4]
        else $error("subsecond readback wrong");

    property p_subsec_only1;
        @(posedge clk_sys) disable iff (rst)
        (match_en[amt_pkg::EN_SUBSEC1] && !field_hit[amt_pkg::EN_SUBSEC1])
        |=> !alm1_hit;
    endproperty
    a_subsec_only1: assert property (p_subsec_only1) // [RULE5]
        else $error("alarm 1 hit despite subsecond mismatch");

    property p_sec_zero;
        @(posedge clk_sys) disable iff (rst)
        s_rd(amt_pkg::ADDR_SEC1) |=> !rdata[7];
    endproperty
    a_sec_zero: assert property (p_sec_zero) // [RULE6]
        else $error("seconds bit 7 not zero");

    property p_min_rt;
        @(posedge clk_sys) disable iff (rst)
        s_wr(amt_pkg::ADDR_MIN1) ##1 s_rd(amt_pkg::ADDR_MIN1)
        |=> rdata == ($past(bus_req.wdata, 2) & amt_pkg::MASK_MIN);
    endproperty
    a_min_rt: assert property (p_min_rt) // [RULE7]
        else $error("minutes readback wrong");

    property p_hour_rt;
        @(posedge clk_sys) disable iff (rst)
        s_wr(amt_pkg::ADDR_HOUR1) ##1 s_rd(amt_pkg::ADDR_HOUR1)
        |=> rdata == ($past(bus_req.wdata, 2) & amt_pkg::MASK_HOUR);
    endproperty
    a_hour_rt: assert property (p_hour_rt) // [RULE8]
        else $error("hours readback wrong");

    property p_sticky_set;
        @(posedge clk_sys) disable iff (rst)
        rise0 |=> irq_status[amt_pkg::IRQ_ALM0] && alm0_hit;
    endproperty
    a_sticky_set: assert property (p_sticky_set) // [RULE9]
        else $error("alarm 0 event lost");

    sequence s_wr_rd(logic [7:0] a);
        s_wr(a) ##1 s_rd(a);
    endsequence

    property p_date_rt;
        @(posedge clk_sys) disable iff (rst)
        s_wr_rd(amt_pkg::ADDR_DATE0)
        |=> rdata == ($past(bus_req.wdata, 2) & amt_pkg::MASK_DATE);
    endproperty
    a_date_rt: assert property (p_date_rt) // [RULE1]
        else $error("date readback wrong");

    property p_month_zero;
        @(posedge clk_sys) disable iff (rst)
        s_rd(amt_pkg::ADDR_MONTH0) |=> rdata[7:5] == 3'b000;
    endproperty
    a_month_zero: assert property (p_month_zero) // [RULE2]
        else $error("month top bits not zero");

    property p_sec_rt;
        @(posedge clk_sys) disable iff (rst)
        s_wr_rd(amt_pkg::ADDR_SEC1)
        |=> rdata == ($past(bus_req.wdata, 2) & amt_pkg::MASK_SEC);
    endproperty
    a_sec_rt: assert property (p_sec_rt) // [RULE6]
        else $error("seconds readback wrong");

    property p_min_zero;
        @(posedge clk_sys) disable iff (rst)
        s_rd(amt_pkg::ADDR_MIN1) |=> !rdata[7];
    endproperty
    a_min_zero: assert property (p_min_zero) // [RULE7]
        else $error("minutes bit 7 not zero");

    // Format and meridiem_or_upper_tens_hour bits keep what was written
    property p_hour_fmt;
        @(posedge clk_sys) disable iff (rst)
        s_wr_rd(amt_pkg::ADDR_HOUR1)
        |=> rdata[amt_pkg::BIT_HOUR_12]
            == $past(bus_req.wdata[amt_pkg::BIT_HOUR_12], 2)
        && rdata[amt_pkg::BIT_MERIDIEM]
            == $past(bus_req.wdata[amt_pkg::BIT_MERIDIEM], 2);
    endproperty
    a_hour_fmt: assert property (p_hour_fmt) // [RULE8]
        else $error("hour format bits lost");

    property p_alm0_fire;
        @(posedge clk_sys) disable iff (rst)
        (match_en[amt_pkg::EN_DATE0] && !match_en[amt_pkg::EN_MONTH0]
            && field_hit[amt_pkg::EN_DATE0])
        |=> alm0_hit;
    endproperty
    a_alm0_fire: assert property (p_alm0_fire) // [RULE9]
        else $error("alarm 0 missed a date match");

    property p_sec_miss;
        @(posedge clk_sys) disable iff (rst)
        (match_en[amt_pkg::EN_SEC1] && !field_hit[amt_pkg::EN_SEC1])
        |=> !alm1_hit;
    endproperty
    a_sec_miss: assert property (p_sec_miss) // [RULE9]
        else $error("alarm 1 hit despite seconds mismatch");

    property p_sticky_set1;
        @(posedge clk_sys) disable iff (rst)
        rise1 |=> irq_status[amt_pkg::IRQ_ALM1] && alm1_hit;
    endproperty
    a_sticky_set1: assert property (p_sticky_set1) // [RULE9]
        else $error("alarm 1 event lost");

endmodule
`default_nettype wire

// >>> sim/amt_alarm_regs_bench.sv
`timescale 1ns/1ns
`default_nettype none
module amt_alarm_regs_bench;
    logic                  clk_sys;
    logic                  rst;
    amt_pkg::amt_bus_req_t bus_req;
    amt_pkg::amt_time_t    now_drv;
    amt_pkg::amt_time_t    base;
    logic [7:0]            rdata;
    logic                  alm0_hit;
    logic                  alm1_hit;
    logic                  irq;
    int                    fails;
    int                    total_checks;
    int                    regm [256];
    int                    st_m;
    int                    prev_m;
    int                    exp_q [$];
    int                    addrs [10];
    int                    a;
    logic [31:0]           lfsr;
    logic                  rd_seen;

    amt_alarm_regs dut (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .bus_req  (bus_req),
        .rdata    (rdata),
        .now      (now_drv),
        .alm0_hit (alm0_hit),
        .alm1_hit (alm1_hit),
        .irq      (irq)
    );

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [7:0] msk(input int x);
        case (x)
            'h10: return amt_pkg::MASK_DATE;
            'h11: return amt_pkg::MASK_MONTH;
            'h12: return amt_pkg::MASK_SUBSEC;
            'h13: return amt_pkg::MASK_SEC;
            'h14: return amt_pkg::MASK_MIN;
            'h15: return amt_pkg::MASK_HOUR;
            'h31: return amt_pkg::MASK_IRQ;
            'h32: return amt_pkg::MASK_EN;
            default: return 8'h00;
        endcase
    endfunction

    // Bit offset of each field inside the packed time struct
    function automatic int pos(input int x);
        case (x)
            'h10: return 8;
            'h11: return 0;
            'h12: return 40;
            'h13: return 32;
            'h14: return 24;
            default: return 16;
        endcase
    endfunction

    function automatic int hit_m(input int lo, input int hi);
        int any;
        int all;
        any = 0;
        all = 1;
        for (int i = lo; i <= hi; i++) begin
            if (regm['h32][i]) begin
                any = 1;
                if (((regm['h10 + i] ^ now_drv[pos('h10 + i) +: 8])
                     & msk('h10 + i)) != 0) begin
                    all = 0;
                end
            end
        end
        return any & all;
    endfunction

////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input int x, input int d);
        bus_req.addr  <= 8'(x);
        bus_req.wdata <= 8'(d);
        bus_req.wr    <= 1'b1;
        bus_req.rd    <= 1'b0;
        @(posedge clk_sys);
        if (x == 'h30) begin
            st_m &= ~d;
        end else begin
            regm[x] = d & msk(x);
        end
    endtask

    task automatic rd_chk(input int x);
        exp_q.push_back(x == 'h30 ? st_m : regm[x]);
        bus_req.addr <= 8'(x);
        bus_req.wr   <= 1'b0;
        bus_req.rd   <= 1'b1;
        @(posedge clk_sys);
    endtask

    // Four edges cover hit, status and irq lags with margin
    task automatic settle;
        int h0;
        int h1;
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        h0 = hit_m(0, 1);
        h1 = hit_m(2, 5);
        st_m |= (h0 | (h1 << 1)) & ~prev_m;
        prev_m = h0 | (h1 << 1);
        chk(8'(alm0_hit), 8'(h0));
        chk(8'(alm1_hit), 8'(h1));
        chk(8'(irq), 8'((st_m & regm['h31]) != 0));
        @(posedge clk_sys);
    endtask

    task automatic set_now(input amt_pkg::amt_time_t t);
        now_drv <= t;
        settle;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

////////////////////////////////////////////////////////////////////////////
    // Read data stand only in the cycle after the strobe, zero otherwise
    always @(posedge clk_sys) begin
        rd_seen <= bus_req.rd && !rst;
    end

    always @(negedge clk_sys) begin
        if (!rst && rd_seen) begin
            chk(rdata, 8'(exp_q.pop_front()));
        end else if (!rst) begin
            chk(rdata, 8'h00);
        end
    end

    // Run takes about 300 cycles; over six times that is a hang
    initial begin
        #200000;
        fails++;
        wrap_up;
    end

    initial begin
        rst = 1'b1;
        bus_req = '0;
        now_drv = '0;
        fails = 0;
        total_checks = 0;
        st_m = 0;
        prev_m = 0;
        lfsr = 32'h2fd20b79;
        foreach (regm[i]) regm[i] = 0;
        addrs = '{'h10, 'h11, 'h12, 'h13, 'h14, 'h15, 'h30, 'h31, 'h32, 'h20};
        base = {8'h59, 8'h47, 8'h33, 8'h52, 8'h28, 8'h12};
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        foreach (addrs[i]) rd_chk(addrs[i]);
        // All ones then read back: unimplemented bits must stay zero
        foreach (addrs[i]) begin
            wr(addrs[i], 'hff);
            rd_chk(addrs[i]);
        end
        wr('h32, 0);
        settle;
        repeat (40) begin
            lfsr = lfsr_next(lfsr);
            a = (lfsr[7:0] % 7 == 6) ? 'h20 : 'h10 + lfsr[7:0] % 7;
            wr(a, lfsr[15:8]);
            rd_chk(a);
        end
        now_drv <= base;
        wr('h31, 'h03);
        for (int i = 0; i < 6; i++) begin
            a = 'h10 + i;
            set_now(base);
            wr('h32, 0);
            wr(a, base[pos(a) +: 8]);
            wr('h32, 1 << i);
            settle;
            set_now(base ^ (48'(~msk(a) & 'hff) << pos(a)));
            set_now(base ^ (48'(i == 5 ? 'h40 : 'h01) << pos(a)));
        end
        rd_chk('h30);
        wr('h31, 0);
        settle;
        wr('h30, 'h03);
        settle;
        rd_chk('h30);
        // Month belongs to alarm 0 only, sub-second to alarm 1 only
        wr('h31, 'h03);
        set_now(base);
        wr('h32, 'h06);
        settle;
        set_now(base ^ 48'h01);
        set_now(base ^ (48'h01 << 40));
        rd_chk('h30);
        settle;
        chk(8'(exp_q.size()), 8'h00);
        wrap_up;
    end
endmodule
`default_nettype wire
